// ### include/cprb_pkg.sv
// Package for the charger power register bank: offsets, reset values,
// field positions and the structs that carry sense, trim and setup bytes.
// Assumes a single system clock shared with the serial slave and sequencer.
package cprb_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [3:0] OFS_SEQ = 4'h0;
   localparam logic [3:0] OFS_EV1 = 4'h1;
   localparam logic [3:0] OFS_EV2 = 4'h2;
   localparam logic [3:0] OFS_LIVE = 4'h3;
   localparam logic [3:0] OFS_SPARE = 4'h4;
   localparam logic [3:0] OFS_CMD = 4'h5;
   localparam logic [3:0] OFS_SUP1 = 4'h6;
   localparam logic [3:0] OFS_SUP2 = 4'h7;
   localparam logic [3:0] OFS_CFG1 = 4'h8;
   localparam logic [3:0] OFS_CFG2 = 4'h9;
   localparam logic [3:0] OFS_VHI = 4'hA;
   localparam logic [3:0] OFS_VLO = 4'hB;
   localparam logic [3:0] OFS_CURRENT_LIMIT_CODE = 4'hC;
   localparam logic [3:0] OFS_AUX = 4'hD;
   localparam logic [3:0] OFS_CFG4 = 4'hE;
   localparam logic [3:0] OFS_CFG5 = 4'hF;

   ////////////////////////////////////////////////////////////////////////
   // Hard-wired values after reset, used until factory storage is copied
   localparam logic [7:0] RST_CMD = 8'h00;
   localparam logic [7:0] RST_SUP1 = 8'h00;
   localparam logic [7:0] RST_SUP2 = 8'h00;
   localparam logic [7:0] RST_CFG1 = 8'h28;
   localparam logic [7:0] RST_CFG2 = 8'hF3;
   localparam logic [7:0] RST_VHI = 8'h32;
   localparam logic [7:0] RST_VLO = 8'h10;
   localparam logic [7:0] RST_CURRENT_LIMIT_CODE = 8'hFF;
   localparam logic [7:0] RST_AUX = 8'h30;
   localparam logic [7:0] RST_CFG4 = 8'h23;
   localparam logic [7:0] RST_CFG5 = 8'h9E;

   ////////////////////////////////////////////////////////////////////////
   // Writable and implemented bits
   localparam logic [7:0] SUP1_BITS = 8'hBD;
   localparam logic [7:0] SUP2_BITS = 8'h7F;
   localparam logic [7:0] CFG1_BITS = 8'hF8;
   localparam logic [7:0] AUX_BITS = 8'h3F;
   localparam logic [7:0] ALL_BITS = 8'hFF;

   // Field positions
   localparam int CMD_ENABLE_BIT = 0;
   localparam int CMD_LOAD_BIT = 1;
   localparam int CFG1_MASK_ALL_BIT = 5;
   localparam int VLO_CODE_MSB = 7;
   localparam int VLO_CODE_LSB = 5;

   // Sequencer position codes
   localparam logic [3:0] SEQ_UVLO = 4'h0;
   localparam logic [3:0] SEQ_MAIN_ON = 4'hA;
   localparam logic [3:0] SEQ_ERROR = 4'hC;

   ////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic cc_mode;
      logic sync_out_of_range;
      logic frequency_set_resistor_bad;
      logic hard_thermal_shutdown;
      logic soft_thermal_shutdown;
      logic input_overvoltage_lockout;
      logic buck_overcurrent;
      logic output_overvoltage;
      logic output_undervoltage;
      logic aux_regulator_undervoltage;
      logic bias_converter_overcurrent;
      logic bias_converter_overvoltage;
      logic bias_converter_undervoltage;
      logic sync_too_high;
      logic sync_too_low;
      logic bias_full_duty;
      logic buck_full_duty;
      logic buck_power_good;
   } cprb_sense_s;

   typedef struct packed {
      logic [7:0] suppress_one;
      logic [7:0] suppress_two;
      logic [7:0] setup_one;
      logic [7:0] setup_two;
      logic [7:0] vout_high;
      logic [7:0] vout_low;
      logic [7:0] current_limit;
      logic [7:0] aux_regulator;
      logic [7:0] setup_four;
      logic [7:0] setup_five;
   } cprb_trim_s;

   localparam cprb_trim_s RST_TRIM = '{RST_SUP1, RST_SUP2, RST_CFG1, RST_CFG2, RST_VHI, RST_VLO,
                                       RST_CURRENT_LIMIT_CODE, RST_AUX, RST_CFG4, RST_CFG5};

   typedef struct packed {
      cprb_sense_s sense_meta;
      cprb_sense_s sense_sync;
      logic cc_prev;
      logic trim_done;
      cprb_trim_s regs;
      logic buck_enable;
      logic [7:0] ev1;
      logic [7:0] ev2;
      logic [10:0] applied_vout;
      logic load_pulse;
      logic [7:0] rd_data;
      logic irq;
   } cprb_state_s;

endpackage

// ### core/cprb_register_bank.sv
// Byte register bank of the charger power controller, behind the serial
// slave's byte port. Sense inputs come from analog detectors and are
// synchronised; sequencer code and factory storage share this clock.
`timescale 1ns/100ps

module cprb_register_bank
   import cprb_pkg::*;
(
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic [3:0] addr_i,
   input wire logic wr_en_i,
   input wire logic [7:0] wr_data_i,
   input wire logic rd_en_i,
   input wire logic [3:0] seq_code_i,
   input wire cprb_sense_s sense_i,
   input wire cprb_trim_s trim_i,
   output logic [7:0] rd_data_o,
   output logic irq_o,
   output cprb_trim_s setup_o,
   output logic buck_enable_o,
   output logic vout_load_o,
   output logic [10:0] output_voltage_code_o
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [7:0] new_v,
                                             input logic [7:0] bits);
      merge_byte = (old_v & ~bits) | (new_v & bits);
   endfunction

   // Set wins over the read-clear in the same cycle
   function automatic logic [7:0] event_next(input logic [7:0] old_v, input logic [7:0] set_v,
                                             input logic clr);
      event_next = (clr ? 8'h00 : old_v) | set_v;
   endfunction

   function automatic cprb_trim_s trim_clean(input cprb_trim_s t);
      cprb_trim_s r;
      r = t;
      r.suppress_one = t.suppress_one & SUP1_BITS;
      r.suppress_two = t.suppress_two & SUP2_BITS;
      r.setup_one = t.setup_one & CFG1_BITS;
      r.aux_regulator = t.aux_regulator & AUX_BITS;
      trim_clean = r;
   endfunction

   cprb_state_s st;
   cprb_state_s next_st;
   logic [7:0] ev1_set;
   logic [7:0] ev2_set;
   logic [7:0] eff1;
   logic [7:0] eff2;
   logic rd_ev1;
   logic rd_ev2;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      next_st = st;
      next_st.sense_meta = sense_i;
      next_st.sense_sync = st.sense_meta;
      next_st.cc_prev = st.sense_sync.cc_mode;
      next_st.load_pulse = 1'b0;

      // Level causes keep re-setting while present, so a read cannot drop them
      ev1_set = {st.sense_sync.cc_mode ^ st.cc_prev,
                 1'b0,
                 st.sense_sync.sync_out_of_range,
                 st.sense_sync.frequency_set_resistor_bad,
                 st.sense_sync.hard_thermal_shutdown,
                 st.sense_sync.soft_thermal_shutdown,
                 1'b0,
                 st.sense_sync.input_overvoltage_lockout};
      ev2_set = {1'b0,
                 st.sense_sync.buck_overcurrent,
                 st.sense_sync.output_overvoltage,
                 st.sense_sync.output_undervoltage,
                 st.sense_sync.aux_regulator_undervoltage,
                 st.sense_sync.bias_converter_overcurrent,
                 st.sense_sync.bias_converter_overvoltage,
                 st.sense_sync.bias_converter_undervoltage};

      rd_ev1 = rd_en_i && (addr_i == OFS_EV1);
      rd_ev2 = rd_en_i && (addr_i == OFS_EV2);
      next_st.ev1 = event_next(st.ev1, ev1_set, rd_ev1);
      next_st.ev2 = event_next(st.ev2, ev2_set, rd_ev2);

      // Factory copy happens once, one edge after reset release
      if (!st.trim_done) begin
         next_st.regs = trim_clean(trim_i);
         next_st.trim_done = 1'b1;
      end else if (wr_en_i) begin
         case (addr_i)
            OFS_CMD: begin
               next_st.buck_enable = wr_data_i[CMD_ENABLE_BIT];
               if (wr_data_i[CMD_LOAD_BIT]) begin
                  next_st.load_pulse = 1'b1;
                  next_st.applied_vout = {st.regs.vout_high,
                                          st.regs.vout_low[VLO_CODE_MSB:VLO_CODE_LSB]};
               end
            end
            OFS_SUP1: next_st.regs.suppress_one = merge_byte(st.regs.suppress_one, wr_data_i, SUP1_BITS);
            OFS_SUP2: next_st.regs.suppress_two = merge_byte(st.regs.suppress_two, wr_data_i, SUP2_BITS);
            OFS_CFG1: next_st.regs.setup_one = merge_byte(st.regs.setup_one, wr_data_i, CFG1_BITS);
            OFS_CFG2: next_st.regs.setup_two = wr_data_i;
            OFS_VHI: next_st.regs.vout_high = wr_data_i;
            OFS_VLO: next_st.regs.vout_low = wr_data_i;
            OFS_CURRENT_LIMIT_CODE: next_st.regs.current_limit = wr_data_i;
            OFS_AUX: next_st.regs.aux_regulator = merge_byte(st.regs.aux_regulator, wr_data_i,
                                                             AUX_BITS);
            OFS_CFG4: next_st.regs.setup_four = wr_data_i;
            OFS_CFG5: next_st.regs.setup_five = wr_data_i;
            default: begin
               // Read-only and reserved offsets ignore writes
            end
         endcase
      end

      // Read data is the value before any clear of this edge
      if (rd_en_i) begin
         unique case (addr_i)
            // Code is passed through each cycle, so short phases are rarely caught
            OFS_SEQ: next_st.rd_data = {4'h0, seq_code_i};
            OFS_EV1: next_st.rd_data = st.ev1;
            OFS_EV2: next_st.rd_data = st.ev2;
            OFS_LIVE: next_st.rd_data = {st.sense_sync.sync_too_high, st.sense_sync.sync_too_low,
                                         st.sense_sync.bias_full_duty, st.sense_sync.cc_mode,
                                         st.sense_sync.buck_full_duty, st.sense_sync.buck_power_good,
                                         2'b00};
            OFS_SPARE: next_st.rd_data = 8'h00;
            OFS_CMD: next_st.rd_data = {7'h00, st.buck_enable};                   // Load bit reads 0
            OFS_SUP1: next_st.rd_data = st.regs.suppress_one;
            OFS_SUP2: next_st.rd_data = st.regs.suppress_two;
            OFS_CFG1: next_st.rd_data = st.regs.setup_one;
            OFS_CFG2: next_st.rd_data = st.regs.setup_two;
            OFS_VHI: next_st.rd_data = st.regs.vout_high;
            OFS_VLO: next_st.rd_data = st.regs.vout_low;
            OFS_CURRENT_LIMIT_CODE: next_st.rd_data = st.regs.current_limit;
            OFS_AUX: next_st.rd_data = st.regs.aux_regulator;
            OFS_CFG4: next_st.rd_data = st.regs.setup_four;
            OFS_CFG5: next_st.rd_data = st.regs.setup_five;
         endcase
      end

      // Masking only gates the output; recording is untouched
      eff1 = next_st.regs.suppress_one | {8{next_st.regs.setup_one[CFG1_MASK_ALL_BIT]}};
      eff2 = next_st.regs.suppress_two | {8{next_st.regs.setup_one[CFG1_MASK_ALL_BIT]}};
      next_st.irq = |((next_st.ev1 & ~eff1) | (next_st.ev2 & ~eff2));
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st <= '0;
         st.regs <= RST_TRIM;
         st.applied_vout <= {RST_VHI, RST_VLO[VLO_CODE_MSB:VLO_CODE_LSB]};
      end else begin
         st <= next_st;
      end
   end

   assign rd_data_o = st.rd_data;
   assign irq_o = st.irq;
   assign setup_o = st.regs;
   assign buck_enable_o = st.buck_enable;
   assign vout_load_o = st.load_pulse;
   assign output_voltage_code_o = st.applied_vout;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rstn_i);

   sequence s_seq_read;
      rd_en_i && (addr_i == OFS_SEQ);
   endsequence

   property p_seq_read;
      s_seq_read |=> (rd_data_o[7:4] == 4'h0) && (rd_data_o[3:0] == $past(seq_code_i));
   endproperty
   a_seq_read: assert property (p_seq_read) else $error("sequencer read value wrong");

   property p_ev_read_value;
      (rd_en_i && (addr_i == OFS_EV1)) |=> (rd_data_o == $past(st.ev1));
   endproperty
   a_ev_read_value: assert property (p_ev_read_value) else $error("event byte read value wrong");

   property p_clear_on_read;
      (rd_en_i && (addr_i == OFS_EV2) && (ev2_set == 8'h00)) |=> (st.ev2 == 8'h00);
   endproperty
   a_clear_on_read: assert property (p_clear_on_read) else $error("event byte not cleared by read");

   property p_persist;
      (rd_en_i && (addr_i == OFS_EV1) && st.sense_sync.hard_thermal_shutdown) |=> st.ev1[3];
   endproperty
   a_persist: assert property (p_persist) else $error("persisting cause cleared by read");

   sequence s_cc_change;
      $changed(st.sense_sync.cc_mode);
   endsequence

   property p_cc_change;
      s_cc_change |=> st.ev1[7] ##1 (st.ev1[7] || $past(rd_ev1));
   endproperty
   a_cc_change: assert property (p_cc_change) else $error("regulation change not recorded");

   property p_sense_to_event;
      $rose(sense_i.input_overvoltage_lockout) |-> ##3 st.ev1[0];
   endproperty
   a_sense_to_event: assert property (p_sense_to_event) else $error("lockout event late");

   property p_unused_zero;
      (st.ev1[6] == 1'b0) && (st.ev1[1] == 1'b0) && (st.ev2[7] == 1'b0);
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused event bit set");

   sequence s_trim_copy;
      !st.trim_done ##1 st.trim_done;
   endsequence

   property p_trim_copy;
      s_trim_copy |-> (st.regs.current_limit == $past(trim_i.current_limit)) &&
                      (st.regs.vout_high == $past(trim_i.vout_high));
   endproperty
   a_trim_copy: assert property (p_trim_copy) else $error("factory defaults not taken");

   // Back-to-back load writes legally keep the pulse high
   property p_load;
      (wr_en_i && st.trim_done && (addr_i == OFS_CMD) && wr_data_i[CMD_LOAD_BIT]) |=>
         vout_load_o && (output_voltage_code_o == {$past(st.regs.vout_high), $past(st.regs.vout_low[7:5])})
         ##1 (!vout_load_o ||
              ($past(wr_en_i) && ($past(addr_i) == OFS_CMD) && $past(wr_data_i[CMD_LOAD_BIT])));
   endproperty
   a_load: assert property (p_load) else $error("voltage code load wrong");

   property p_aux_width;
      st.regs.aux_regulator[7:6] == 2'b00;
   endproperty
   a_aux_width: assert property (p_aux_width) else $error("aux code upper bits set");

   property p_spare;
      (rd_en_i && (addr_i == OFS_SPARE)) |=> (rd_data_o == 8'h00);
   endproperty
   a_spare: assert property (p_spare) else $error("reserved offset not zero");

   property p_masked;
      ((st.regs.suppress_one == SUP1_BITS) && (st.regs.suppress_two == SUP2_BITS)) |-> !irq_o;
   endproperty
   a_masked: assert property (p_masked) else $error("masked event raised interrupt");

   property p_mask_all;
      st.regs.setup_one[CFG1_MASK_ALL_BIT] |-> !irq_o;
   endproperty
   a_mask_all: assert property (p_mask_all) else $error("mask-all did not block interrupt");

   property p_irq_level;
      irq_o == (|((st.ev1 & ~st.regs.suppress_one) | (st.ev2 & ~st.regs.suppress_two)) &&
                !st.regs.setup_one[CFG1_MASK_ALL_BIT]);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt level mismatch");

   property p_ev2_read_value;
      (rd_en_i && (addr_i == OFS_EV2)) |=> (rd_data_o == $past(st.ev2));
   endproperty
   a_ev2_read_value: assert property (p_ev2_read_value) else $error("event byte two read value wrong");

   property p_ro_write;
      (wr_en_i && st.trim_done && (addr_i <= OFS_SPARE)) |=> $stable(setup_o);
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("write to read-only offset changed a register");

   property p_vout_hold;
      !vout_load_o |-> $stable(output_voltage_code_o);
   endproperty
   a_vout_hold: assert property (p_vout_hold) else $error("voltage code moved without load");

   property p_current_limit_code_write;
      (wr_en_i && st.trim_done && (addr_i == OFS_CURRENT_LIMIT_CODE)) |=> (setup_o.current_limit == $past(wr_data_i));
   endproperty
   a_current_limit_code_write: assert property (p_current_limit_code_write) else $error("current limit write lost");

   property p_sync_event;
      $rose(sense_i.sync_out_of_range) |-> ##3 st.ev1[5];
   endproperty
   a_sync_event: assert property (p_sync_event) else $error("sync range event late");

   property p_freq_event;
      $rose(sense_i.frequency_set_resistor_bad) |-> ##3 st.ev1[4];
   endproperty
   a_freq_event: assert property (p_freq_event) else $error("frequency resistor event late");

   property p_hard_event;
      $rose(sense_i.hard_thermal_shutdown) |-> ##3 st.ev1[3];
   endproperty
   a_hard_event: assert property (p_hard_event) else $error("hard thermal event late");

   property p_ocp_event;
      $rose(sense_i.buck_overcurrent) |-> ##3 st.ev2[6];
   endproperty
   a_ocp_event: assert property (p_ocp_event) else $error("converter over-current event late");

   property p_ovp_event;
      $rose(sense_i.output_overvoltage) |-> ##3 st.ev2[5];
   endproperty
   a_ovp_event: assert property (p_ovp_event) else $error("output over-voltage event late");

   property p_uvp_event;
      $rose(sense_i.output_undervoltage) |-> ##3 st.ev2[4];
   endproperty
   a_uvp_event: assert property (p_uvp_event) else $error("output under-voltage event late");

   property p_aux_event;
      $rose(sense_i.aux_regulator_undervoltage) |-> ##3 st.ev2[3];
   endproperty
   a_aux_event: assert property (p_aux_event) else $error("aux regulator event late");

   property p_bias_oc_event;
      $rose(sense_i.bias_converter_overcurrent) |-> ##3 st.ev2[2];
   endproperty
   a_bias_oc_event: assert property (p_bias_oc_event) else $error("bias over-current event late");

   property p_bias_ov_event;
      $rose(sense_i.bias_converter_overvoltage) |-> ##3 st.ev2[1];
   endproperty
   a_bias_ov_event: assert property (p_bias_ov_event) else $error("bias over-voltage event late");

   property p_masked_recorded;
      (st.regs.suppress_two[5] && st.sense_sync.output_overvoltage) |=> st.ev2[5];
   endproperty
   a_masked_recorded: assert property (p_masked_recorded) else $error("masked event not recorded");

endmodule // cprb_register_bank

// ### verification/cprb_env_model.sv
// Far-side model: factory trim storage, power sequencer and analog detectors.
// Assumes the bench requests state codes and detector levels on the system clock.
`timescale 1ns/100ps

module cprb_env_model
   import cprb_pkg::*;
#(
   parameter cprb_trim_s TRIM = RST_TRIM
)
(
   input wire logic clock_i,
   input wire logic [3:0] seq_req_i,
   input wire logic [17:0] sense_req_i,
   output logic [3:0] seq_code_o,
   output cprb_sense_s sense_o,
   output cprb_trim_s trim_o
);
   // Storage is constant, so it is stable from reset release
   assign trim_o = TRIM;

   always_ff @(posedge clock_i) begin
      seq_code_o <= seq_req_i;
      sense_o <= cprb_sense_s'(sense_req_i);
   end
endmodule // cprb_env_model

// ### verification/cprb_register_bank_tb_top.sv
// Self-checking bench for the charger power register bank byte port.
// Assumes one 10 MHz clock and the environment model on the far side.
`timescale 1ns/100ps

module cprb_register_bank_tb_top;
   import cprb_pkg::*;
   // Factory bytes differ from fixed defaults, except current limit, and suppress two and setup one after masking, so the copy is visible
   localparam cprb_trim_s FTRIM = '{8'hFF, 8'h80, 8'h2F, 8'h5A, 8'h64, 8'hA0, 8'hFF, 8'hFF, 8'h11, 8'h22};
   localparam logic [79:0] IMPL = {SUP1_BITS, SUP2_BITS, CFG1_BITS, {4{ALL_BITS}}, AUX_BITS, ALL_BITS, ALL_BITS};
   localparam logic [79:0] EXP_TRIM = FTRIM & IMPL;
   localparam logic [39:0] EV1_TAB = {8'h20, 8'h10, 8'h08, 8'h04, 8'h01};

   logic clock_i, rstn_i, wr_en, rd_en, irq, buck_en, vload;
   logic [3:0] addr, seq_req, seq_code;
   logic [7:0] wr_data, rd_data, ebit;
   logic [17:0] sense_req;
   logic [10:0] vcode;
   cprb_sense_s sense;
   cprb_trim_s trim, setup;
   logic [3:0] ofs;
   int miscompares, n_tests, i;

   always #50 clock_i = ~clock_i;

   cprb_env_model #(.TRIM(FTRIM)) env_u (.clock_i(clock_i), .seq_req_i(seq_req), .sense_req_i(sense_req),
      .seq_code_o(seq_code), .sense_o(sense), .trim_o(trim));

   cprb_register_bank dut_u (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr), .wr_en_i(wr_en),
      .wr_data_i(wr_data), .rd_en_i(rd_en), .seq_code_i(seq_code), .sense_i(sense), .trim_i(trim),
      .rd_data_o(rd_data), .irq_o(irq), .setup_o(setup), .buck_enable_o(buck_en), .vout_load_o(vload),
      .output_voltage_code_o(vcode));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [79:0] seen, input logic [79:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clock_i);
      wr_en <= 1'b0;
   endtask

   // Read data is registered, so it is looked at on the falling edge half a cycle after the read edge
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clock_i);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock_i);
      rd_en <= 1'b0;
      @(negedge clock_i);
      chk($sformatf("read %0h", a), {72'h0, rd_data}, {72'h0, exp});
   endtask

   task automatic summarize;
      if (miscompares == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clock_i);
      miscompares++;
      summarize;
   end

   initial begin
      clock_i = 1'b0;
      rstn_i = 1'b0;
      addr = 4'h0;
      wr_en = 1'b0;
      wr_data = 8'h00;
      rd_en = 1'b0;
      seq_req = 4'h0;
      sense_req = 18'h0;
      tick(16);
      @(negedge clock_i);
      chk("setup in reset", setup, RST_TRIM);
      chk("vcode in reset", {69'h0, vcode}, {69'h0, RST_VHI, 3'b000});
      @(posedge clock_i) rstn_i <= 1'b1;
      tick(3);
      @(negedge clock_i);
      chk("setup after copy", setup, EXP_TRIM);
      for (i = 0; i < 10; i++) rd(4'(OFS_SUP1 + i), EXP_TRIM[79 - 8 * i -: 8]);
      rd(OFS_CMD, RST_CMD);
      rd(OFS_EV1, 8'h00);
      rd(OFS_EV2, 8'h00);
      for (i = 0; i < 13; i++) begin
         @(posedge clock_i) seq_req <= i[3:0];
         tick(2);
         rd(OFS_SEQ, {4'h0, i[3:0]});
      end
      // Live flags pass straight through; bits 4 and 1:0 stay low
      @(posedge clock_i) sense_req[4:0] <= 5'h1F;
      tick(4);
      rd(OFS_LIVE, 8'hEC);
      @(posedge clock_i) sense_req[4:0] <= 5'h00;
      tick(4);
      // Read-only places ignore writes
      wr(OFS_SPARE, 8'hFF);
      wr(OFS_EV1, 8'hFF);
      wr(OFS_SEQ, 8'hFF);
      rd(OFS_SPARE, 8'h00);
      rd(OFS_EV1, 8'h00);
      rd(OFS_SEQ, 8'h0C);
      wr(OFS_CURRENT_LIMIT_CODE, 8'h5A);
      rd(OFS_CURRENT_LIMIT_CODE, 8'h5A);
      wr(OFS_AUX, 8'hFF);
      rd(OFS_AUX, 8'h3F);
      // Voltage code moves only on the load command
      wr(OFS_VHI, 8'hAB);
      wr(OFS_VLO, 8'hE0);
      chk("vcode before load", {69'h0, vcode}, {69'h0, RST_VHI, RST_VLO[VLO_CODE_MSB:VLO_CODE_LSB]});
      wr(OFS_CMD, 8'h03);
      @(negedge clock_i);
      chk("load pulse", {79'h0, vload}, 80'h1);
      chk("vcode", {69'h0, vcode}, {69'h0, 8'hAB, 3'b111});
      chk("enable", {79'h0, buck_en}, 80'h1);
      @(negedge clock_i);
      chk("load pulse end", {79'h0, vload}, 80'h0);
      rd(OFS_CMD, 8'h01);
      // Unmask everything, then walk each level cause
      wr(OFS_CFG1, 8'h08);
      wr(OFS_SUP1, 8'h00);
      wr(OFS_SUP2, 8'h00);
      for (i = 0; i < 12; i++) begin
         ofs = (i < 5) ? OFS_EV1 : OFS_EV2;
         ebit = (i < 5) ? EV1_TAB[39 - 8 * i -: 8] : 8'(8'h01 << (11 - i));
         @(posedge clock_i) sense_req[16 - i] <= 1'b1;
         tick(6);
         @(negedge clock_i);
         chk("irq raised", {79'h0, irq}, 80'h1);
         rd(ofs, ebit);
         rd(ofs, ebit);
         @(posedge clock_i) sense_req[16 - i] <= 1'b0;
         tick(6);
         rd(ofs, ebit);
         rd(ofs, 8'h00);
         chk("irq released", {79'h0, irq}, 80'h0);
      end
      // Regulation mode change in both directions
      @(posedge clock_i) sense_req[17] <= 1'b1;
      tick(6);
      rd(OFS_EV1, 8'h80);
      rd(OFS_EV1, 8'h00);
      @(posedge clock_i) sense_req[17] <= 1'b0;
      tick(6);
      rd(OFS_EV1, 8'h80);
      rd(OFS_EV1, 8'h00);
      // Masked event is still recorded
      wr(OFS_SUP2, 8'h20);
      @(posedge clock_i) sense_req[10] <= 1'b1;
      tick(6);
      @(negedge clock_i);
      chk("irq masked", {79'h0, irq}, 80'h0);
      rd(OFS_EV2, 8'h20);
      wr(OFS_SUP2, 8'h00);
      tick(2);
      @(negedge clock_i);
      chk("irq unmasked", {79'h0, irq}, 80'h1);
      wr(OFS_CFG1, 8'h28);
      tick(2);
      @(negedge clock_i);
      chk("irq mask all", {79'h0, irq}, 80'h0);
      @(posedge clock_i) sense_req[10] <= 1'b0;
      tick(6);
      rd(OFS_EV2, 8'h20);
      rd(OFS_EV2, 8'h00);
      summarize;
   end
endmodule // cprb_register_bank_tb_top
